// [design/gpic_ctrl.v]
// Purpose: Grouped four-level priority interrupt controller.
// Assumes: Requests are single-cycle pulses synchronous to clk_sys_i,
//          except the external non-maskable pin which is synchronised.
// Notes:   Hands a vector to the core as a registered request held until ack; the core
//          acknowledges acceptance with ack and signals return with return_from_interrupt.
//
// Our own choices: strobed register access and the register offsets.
`include "gpic_regs.vh"

module gpic_ctrl (
  input  wire        clk_sys_i,
  input  wire        resetn_i,
  input  wire [23:0] src_req_i,
  input  wire        nmi_pin_i,
  input  wire        cpu_ack_i,
  input  wire        cpu_return_from_interrupt_i,
  input  wire [3:0]  reg_addr_i,
  input  wire [7:0]  reg_wdata_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  output reg  [7:0]  reg_rdata_o,
  output reg         irq_req_o,
  output reg  [15:0] irq_vector_o,
  output reg  [15:0] boot_vector_o,
  output reg         irq_line_o
);

  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_PRES = 2'h2;

  reg [7:0]  irq_enable_reg_0_ff;
  reg [7:0]  irq_enable_reg_1_ff;
  reg [7:0]  irq_enable_reg_2_ff;
  reg [7:0]  irq_enable_reg_3_ff;
  reg [7:0]  priority_bit_reg_a_ff;
  reg [7:0]  priority_bit_reg_b_ff;
  reg [7:0]  power_control_reg_ff;
  reg [23:0] flag_ff;
  reg [1:0]  state_ff;
  reg [3:0]  lat_ff;
  reg [4:0]  win_src_ff;
  reg        win_nmi_ff;
  reg [2:0]  act_lvl_ff;
  reg [4:0]  stk_ptr_ff;
  reg [11:0] lvl_stack_ff;
  reg        nmi_meta_ff;
  reg        nmi_sync_ff;
  reg        nmi_prev_ff;
  reg        nmi_pend_ff;

  wire        global_irq_enable;
  wire [23:0] en_vec;
  wire [23:0] live;
  wire [5:0]  grp_any;
  wire [11:0] grp_sel;
  wire        ctl_write;
  wire        nmi_rise;

  // Global enable lives in bit 7 of the first enable register
  assign global_irq_enable = irq_enable_reg_0_ff[`GPIC_GIE_BIT];  // [R7]
  assign en_vec = {irq_enable_reg_3_ff[5:0], irq_enable_reg_2_ff[5:0],
                   irq_enable_reg_1_ff[5:0], irq_enable_reg_0_ff[5:0]}; // [R6]
  // Source only eligible with both its bit and the global bit set
  assign live = flag_ff & en_vec & {24{global_irq_enable}};       // [R8]
  assign ctl_write = reg_wr_i && (reg_addr_i <= `GPIC_OFS_PWR);   // [R17]
  assign nmi_rise = nmi_sync_ff && !nmi_prev_ff;

  // One arbiter per group, members g, g+6, g+12, g+18
  genvar g;
  generate
    for (g = 0; g < `GPIC_NUM_GRP; g = g + 1) begin : grp
      gpic_group_arb u_arb (
        .req_i ({live[g+18], live[g+12], live[g+6], live[g]}),    // [R3]
        .any_o (grp_any[g]),
        .sel_o (grp_sel[2*g+1:2*g])
      );
    end
  endgenerate

  // Level of a group: one bit from each priority register
  function [1:0] grp_lvl;
    input [2:0] gi;
    begin
      grp_lvl = {priority_bit_reg_b_ff[gi],
                 priority_bit_reg_a_ff[gi]};                      // [R14] [R11]
    end
  endfunction

  // Best level first, then lowest group number
  reg [2:0] best_grp;
  reg [1:0] best_lvl;
  reg       best_any;
  reg [4:0] best_src;
  integer   i;
  always @* begin
    best_grp = 3'h0;
    best_lvl = 2'h0;
    best_any = 1'b0;
    best_src = 5'h00;
    for (i = 0; i < `GPIC_NUM_GRP; i = i + 1) begin
      if (grp_any[i] && (!best_any || grp_lvl(i[2:0]) > best_lvl)) begin
        best_any = 1'b1;                                          // [R4] [R1]
        best_grp = i[2:0];
        best_lvl = grp_lvl(i[2:0]);
      end
    end
    best_src = best_grp + 5'd6 * {3'h0, grp_sel[2*best_grp +: 2]};
  end

  // Best pending level plus one, on the act_lvl_ff scale where 0 means base level; level 3 and NMI both give 4
  wire [2:0] cand_lvl = {1'b0, best_lvl} + 3'h1;
  // Group of the source being accepted, sized to stay 5 bits wide
  wire [4:0] win_grp  = win_src_ff % 5'd6;
  wire       can_take = nmi_pend_ff ||
                        (best_any && cand_lvl > act_lvl_ff);      // [R18]

  // Vector from source index, eight-byte stride
  function [15:0] vec_of;
    input [4:0] s;
    begin
      vec_of = `GPIC_VEC_BASE + {8'h00, s, 3'h0};                 // [R13] [R15]
    end
  endfunction

  // Pin level for the non-maskable input crosses two flops first
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      nmi_meta_ff <= 1'b0;
      nmi_sync_ff <= 1'b0;
      nmi_prev_ff <= 1'b0;
    end else begin
      nmi_meta_ff <= nmi_pin_i;
      nmi_sync_ff <= nmi_meta_ff;
      nmi_prev_ff <= nmi_sync_ff;
    end
  end

  // Control registers, global enable auto-clear and restore
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_enable_reg_0_ff   <= `GPIC_RST_EN;
      irq_enable_reg_1_ff   <= `GPIC_RST_EN;
      irq_enable_reg_2_ff   <= `GPIC_RST_EN;
      irq_enable_reg_3_ff   <= `GPIC_RST_EN;
      priority_bit_reg_a_ff <= `GPIC_RST_PRI;
      priority_bit_reg_b_ff <= `GPIC_RST_PRI;
      power_control_reg_ff  <= `GPIC_RST_PWR;
    end else begin
      if (reg_wr_i) begin
        case (reg_addr_i)
          `GPIC_OFS_EN0:  irq_enable_reg_0_ff   <= reg_wdata_i;
          `GPIC_OFS_EN1:  irq_enable_reg_1_ff   <= reg_wdata_i;
          `GPIC_OFS_EN2:  irq_enable_reg_2_ff   <= reg_wdata_i;
          `GPIC_OFS_EN3:  irq_enable_reg_3_ff   <= reg_wdata_i;
          `GPIC_OFS_PRIA: priority_bit_reg_a_ff <= reg_wdata_i;
          `GPIC_OFS_PRIB: priority_bit_reg_b_ff <= reg_wdata_i;
          `GPIC_OFS_PWR:  power_control_reg_ff  <= reg_wdata_i;
          default: ;
        endcase
      end
      // Hardware actions win over a software write in the same cycle
      if (cpu_ack_i && state_ff == ST_PRES) begin
        irq_enable_reg_0_ff[`GPIC_GIE_BIT] <= 1'b0;               // [R9]
      end else if (cpu_return_from_interrupt_i) begin
        irq_enable_reg_0_ff[`GPIC_GIE_BIT] <= 1'b1;               // [R10]
      end
    end
  end

  // Request flags: set wins over the acceptance clear
  reg [23:0] nxt_flag;
  always @* begin
    nxt_flag = flag_ff;
    if (cpu_ack_i && state_ff == ST_PRES && !win_nmi_ff) begin
      nxt_flag[win_src_ff] = 1'b0;                                // [R16]
    end
    nxt_flag = nxt_flag | src_req_i;                              // [R16]
  end

  // Acceptance sequence: wait minimum latency, present, await ack
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flag_ff      <= 24'h000000;
      state_ff     <= ST_IDLE;
      lat_ff       <= 4'h0;
      win_src_ff   <= 5'h00;
      win_nmi_ff   <= 1'b0;
      act_lvl_ff   <= 3'h0;
      stk_ptr_ff   <= 5'h00;
      lvl_stack_ff <= 12'h000;
      nmi_pend_ff  <= 1'b0;
      irq_req_o    <= 1'b0;
      irq_vector_o <= `GPIC_VEC_RESET;                            // [R12]
    end else begin
      flag_ff <= nxt_flag;
      if (nmi_rise) begin
        nmi_pend_ff <= 1'b1;                                      // [R2]
      end else if (cpu_ack_i && state_ff == ST_PRES && win_nmi_ff) begin
        nmi_pend_ff <= 1'b0;
      end
      // Pop the nesting level on return
      if (cpu_return_from_interrupt_i && stk_ptr_ff != 5'h00) begin
        act_lvl_ff   <= lvl_stack_ff[2:0];
        lvl_stack_ff <= {3'h0, lvl_stack_ff[11:3]};
        stk_ptr_ff   <= stk_ptr_ff - 5'h01;
      end
      case (state_ff)
        ST_IDLE: begin
          lat_ff <= 4'h0;
          if (can_take && !ctl_write) begin                       // [R17]
            state_ff <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          lat_ff <= lat_ff + 4'h1;
          if (!can_take) begin
            state_ff <= ST_IDLE;
          end else if (ctl_write) begin
            lat_ff <= lat_ff;                                     // [R17]
          end else if (lat_ff >= `GPIC_LAT_WAIT) begin            // [R5]
            state_ff     <= ST_PRES;
            irq_req_o    <= 1'b1;
            win_nmi_ff   <= nmi_pend_ff;                          // [R2]
            win_src_ff   <= best_src;
            irq_vector_o <= nmi_pend_ff ? `GPIC_VEC_RESET
                                        : vec_of(best_src);       // [R13]
          end
        end
        ST_PRES: begin
          if (cpu_ack_i) begin
            irq_req_o    <= 1'b0;
            state_ff     <= ST_IDLE;
            act_lvl_ff   <= win_nmi_ff ? 3'h4
                          : {1'b0, grp_lvl(win_grp[2:0])} + 3'h1;
            lvl_stack_ff <= {lvl_stack_ff[8:0], act_lvl_ff};
            stk_ptr_ff   <= stk_ptr_ff + 5'h01;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // Read data one cycle after the strobe
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_o   <= 8'h00;
      boot_vector_o <= `GPIC_VEC_RESET;                           // [R12]
      irq_line_o    <= 1'b0;
    end else begin
      boot_vector_o <= `GPIC_VEC_RESET;
      irq_line_o    <= |live || nmi_pend_ff;
      if (reg_rd_i) begin
        case (reg_addr_i)
          `GPIC_OFS_EN0:    reg_rdata_o <= irq_enable_reg_0_ff;
          `GPIC_OFS_EN1:    reg_rdata_o <= irq_enable_reg_1_ff;
          `GPIC_OFS_EN2:    reg_rdata_o <= irq_enable_reg_2_ff;
          `GPIC_OFS_EN3:    reg_rdata_o <= irq_enable_reg_3_ff;
          `GPIC_OFS_PRIA:   reg_rdata_o <= priority_bit_reg_a_ff;
          `GPIC_OFS_PRIB:   reg_rdata_o <= priority_bit_reg_b_ff;
          `GPIC_OFS_PWR:    reg_rdata_o <= power_control_reg_ff;
          `GPIC_OFS_FLAG0:  reg_rdata_o <= {2'h0, flag_ff[5:0]};
          `GPIC_OFS_FLAG1:  reg_rdata_o <= {2'h0, flag_ff[11:6]};
          `GPIC_OFS_FLAG2:  reg_rdata_o <= {2'h0, flag_ff[17:12]};
          `GPIC_OFS_FLAG3:  reg_rdata_o <= {2'h0, flag_ff[23:18]};
          `GPIC_OFS_STATUS: reg_rdata_o <= {nmi_pend_ff, act_lvl_ff,
                                            2'h0, state_ff};
          default:          reg_rdata_o <= 8'h00;
        endcase
      end else begin
        reg_rdata_o <= 8'h00;
      end
    end
  end

endmodule // gpic_ctrl

// [design/gpic_group_arb.v]
// Purpose: Pick the highest ranked pending member of one priority group.
// Assumes: Members ordered g, g+6, g+12, g+18; lowest index ranks highest.
// Notes:   Pure combinational; one instance per group.
module gpic_group_arb (
  input  wire [3:0] req_i,
  output reg        any_o,
  output reg  [1:0] sel_o
);

  // Fixed rank inside the group, lower member wins
  always @* begin
    any_o = |req_i;
    if (req_i[0]) begin
      sel_o = 2'h0;                              // [R3]
    end else if (req_i[1]) begin
      sel_o = 2'h1;
    end else if (req_i[2]) begin
      sel_o = 2'h2;
    end else begin
      sel_o = 2'h3;
    end
  end

endmodule // gpic_group_arb

// [shared/gpic_regs.vh]
// Purpose: Register offsets, fields, reset values and timing for the
//          grouped priority interrupt controller.
// Assumes: Plain register port, byte-wide registers, one clock at 100 MHz.
// Notes:   Included by the controller design file only.
//
// Summary of operation
// R1 - Twenty-four sources, each at one of four levels
// R2 - Non-maskable request always enabled, highest priority
// R3 - Six groups; g, g+6, g+12, g+18 ranked
// R4 - Higher level presented first when simultaneous
// R5 - Single request serviced within three to nine cycles
// R6 - Four enable registers, one bit per source
// R7 - Bit 7 of first enable is global
// R8 - Global clear blocks all maskable; else per-bit
// R9 - Taking interrupt clears global enable, gives vector
// R10 - Return from interrupt sets global enable again
// R11 - Priority level from two priority registers
// R12 - Reset vector is address 0000
// R13 - Fixed vectors spaced eight bytes apart
// R14 - Group level: bit g of each priority register
// R15 - Vectors 0003 to 00bb; call pushes program counter
// R16 - Request flag held until accepted, then cleared
// R17 - Acceptance postponed during control register writes
// R18 - Higher level request preempts routine in service
`ifndef GPIC_REGS_VH
`define GPIC_REGS_VH

`define GPIC_NUM_SRC        24
`define GPIC_NUM_GRP        6
`define GPIC_LVL_W          2

// Register offsets on the plain port
`define GPIC_ADDR_W         4
`define GPIC_OFS_EN0        4'h0
`define GPIC_OFS_EN1        4'h1
`define GPIC_OFS_EN2        4'h2
`define GPIC_OFS_EN3        4'h3
`define GPIC_OFS_PRIA       4'h4
`define GPIC_OFS_PRIB       4'h5
`define GPIC_OFS_PWR        4'h6
`define GPIC_OFS_FLAG0      4'h8
`define GPIC_OFS_FLAG1      4'h9
`define GPIC_OFS_FLAG2      4'ha
`define GPIC_OFS_FLAG3      4'hb
`define GPIC_OFS_STATUS     4'hc

// Fields
`define GPIC_GIE_BIT        7
`define GPIC_SRC_PER_REG    6

// Reset values
`define GPIC_RST_EN         8'h00
`define GPIC_RST_PRI        8'h00
`define GPIC_RST_PWR        8'h00

// Vectors
`define GPIC_VEC_RESET      16'h0000
`define GPIC_VEC_BASE       16'h0003
`define GPIC_VEC_STRIDE     16'h0008

// Timing: latency window in machine cycles, two clocks per machine cycle
`define GPIC_CLK_PER_MC     2
`define GPIC_LAT_MIN_MC     3
`define GPIC_LAT_MAX_MC     9
`define GPIC_LAT_MIN_CYC    (`GPIC_LAT_MIN_MC * `GPIC_CLK_PER_MC)
// Wait-state count; flag capture and idle add two, giving the minimum
`define GPIC_LAT_WAIT       4'h4

`endif

// [test/gpic_checker.sv]
// Purpose: Port-level checks of the interrupt controller.
// Assumes: One clock domain, async active-low reset.
// Notes:   Bound into every gpic_ctrl instance.
module gpic_checker (
  input wire        clk_sys_i,
  input wire        resetn_i,
  input wire        nmi_pin_i,
  input wire        cpu_ack_i,
  input wire [3:0]  reg_addr_i,
  input wire        reg_wr_i,
  input wire        reg_rd_i,
  input wire [7:0]  reg_rdata_o,
  input wire        irq_req_o,
  input wire [15:0] irq_vector_o,
  input wire [15:0] boot_vector_o,
  input wire        irq_line_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  // Core takes the presented request
  sequence s_ack;
    irq_req_o && cpu_ack_i;
  endsequence
  // Control write while nothing is presented
  sequence s_ctl_wr;
    reg_wr_i && reg_addr_i < 4'h7 && !irq_req_o;
  endsequence
  property p_boot;
    boot_vector_o == 16'h0000;
  endproperty
  property p_hold;
    irq_req_o && !cpu_ack_i |=> irq_req_o;
  endproperty
  property p_ack;
    s_ack |=> !irq_req_o;
  endproperty
  property p_vec;
    irq_req_o |-> irq_vector_o == 16'h0000 ||
      (irq_vector_o[2:0] == 3'h3 && irq_vector_o <= 16'h00bb);
  endproperty
  property p_line;
    $rose(irq_req_o) |-> $past(irq_line_o);
  endproperty
  // A write freezes the latency count, so nothing can rise
  property p_stall;
    s_ctl_wr |=> !irq_req_o;
  endproperty
  // Sync plus latency fits well inside forty cycles
  property p_nmi;
    $rose(nmi_pin_i) |-> ##[1:40] (irq_req_o && irq_vector_o == 16'h0000);
  endproperty
  property p_rdata;
    !$past(reg_rd_i) |-> reg_rdata_o == 8'h00;
  endproperty
  a_boot: assert property (p_boot)
    else $error("boot vector not zero");
  a_hold: assert property (p_hold)
    else $error("request dropped before acknowledge");
  a_ack: assert property (p_ack)
    else $error("request stands after acknowledge");
  a_vec: assert property (p_vec)
    else $error("vector outside table");
  a_line: assert property (p_line)
    else $error("request without pending line");
  a_stall: assert property (p_stall)
    else $error("request rose across control write");
  a_nmi: assert property (p_nmi)
    else $error("non-maskable request not presented");
  a_rdata: assert property (p_rdata)
    else $error("read data outside read slot");
endmodule // gpic_checker

bind gpic_ctrl gpic_checker i_chk (.clk_sys_i, .resetn_i, .nmi_pin_i,
  .cpu_ack_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
  .irq_req_o, .irq_vector_o, .boot_vector_o, .irq_line_o);

// [test/gpic_cpu_model.sv]
// Purpose: Core model that accepts vectors and returns from service.
// Assumes: Acknowledge only while a request is presented.
// Notes:   Slow mode waits four cycles; service lasts ten cycles.
module gpic_cpu_model (
  input  wire logic        clk_sys_i,
  input  wire logic        resetn_i,
  input  wire logic        irq_req_i,
  input  wire logic [15:0] irq_vector_i,
  input  wire logic        slow_i,
  output logic             cpu_ack_o,
  output logic             cpu_return_from_interrupt_o,
  output logic [15:0]      taken_vec_o,
  output logic [3:0]       taken_cnt_o
);
  logic [1:0] dly_ff;
  logic [3:0] svc_ff;
  // Acknowledge, capture the vector, return after service
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cpu_ack_o   <= 1'h0;
      cpu_return_from_interrupt_o  <= 1'h0;
      taken_vec_o <= 16'hffff;
      taken_cnt_o <= 4'h0;
      dly_ff      <= 2'h0;
      svc_ff      <= 4'h0;
    end else begin
      cpu_ack_o  <= 1'h0;
      cpu_return_from_interrupt_o <= 1'h0;
      if (cpu_ack_o) begin
        taken_vec_o <= irq_vector_i;
        taken_cnt_o <= taken_cnt_o + 4'h1;
        dly_ff      <= 2'h0;
      end else if (irq_req_i) begin
        cpu_ack_o <= !slow_i || dly_ff == 2'h3;
        dly_ff    <= dly_ff + 2'h1;
      end
      // Only one level of service tracked; nesting is not exercised
      if (cpu_ack_o)
        svc_ff <= 4'ha;
      else if (svc_ff != 4'h0)
        svc_ff <= svc_ff - 4'h1;
      if (svc_ff == 4'h1)
        cpu_return_from_interrupt_o <= 1'h1;
    end
  end
endmodule // gpic_cpu_model

// [test/gpic_ctrl_tb.sv]
// Purpose: Self-checking bench of the interrupt controller.
// Assumes: Core model on the vector side, bench on registers.
// Notes:   A scenario ending in take can leave the model's return still pending.
module gpic_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'h0;
  logic        resetn = 1'h0;
  logic [23:0] src_req = 24'h0;
  logic        nmi_pin = 1'h0;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'h0;
  logic        reg_rd = 1'h0;
  logic        slow = 1'h0;
  logic [7:0]  rdata, rd_val;
  logic        irq_req, irq_line, ack, return_from_interrupt;
  logic [15:0] irq_vec, boot_vec, taken_vec;
  logic [3:0]  taken_cnt;
  int          mismatches = 0;
  int          n_compared = 0;
  always #5 clk_sys = ~clk_sys;
  gpic_ctrl i_dut (.clk_sys_i(clk_sys), .resetn_i(resetn),
    .src_req_i(src_req), .nmi_pin_i(nmi_pin), .cpu_ack_i(ack),
    .cpu_return_from_interrupt_i(return_from_interrupt), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata),
    .irq_req_o(irq_req), .irq_vector_o(irq_vec),
    .boot_vector_o(boot_vec), .irq_line_o(irq_line));
  gpic_cpu_model i_cpu (.clk_sys_i(clk_sys), .resetn_i(resetn),
    .irq_req_i(irq_req), .irq_vector_i(irq_vec), .slow_i(slow),
    .cpu_ack_o(ack), .cpu_return_from_interrupt_o(return_from_interrupt), .taken_vec_o(taken_vec),
    .taken_cnt_o(taken_cnt));
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'h1;
    @(posedge clk_sys);
    reg_wr <= 1'h0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'h1;
    @(posedge clk_sys);
    reg_rd <= 1'h0;
    #1 rd_val = rdata;
  endtask
  // Idle first so a pending return from the last service lands
  task automatic pulse(input logic [23:0] m);
    repeat (12) @(posedge clk_sys);
    src_req <= m;
    @(posedge clk_sys);
    src_req <= 24'h0;
    #1;
  endtask
  task automatic take(input logic [15:0] v);
    logic [3:0] c0;
    c0 = taken_cnt;
    for (int n = 0; n < 80 && taken_cnt === c0; n++) @(posedge clk_sys) #1;
    chk("taken count", {12'h0, c0 + 4'h1}, {12'h0, taken_cnt});
    chk("vector", v, taken_vec);
  endtask
  task automatic t_reset;
    for (int a = 0; a < 8; a++) begin
      rd(a[3:0]);
      chk("reg after reset", 16'h0, {8'h0, rd_val});
    end
    wr(4'h8, 8'hff);
    rd(4'h8);
    chk("flag read only", 16'h0, {8'h0, rd_val});
    chk("boot vector", 16'h0000, boot_vec);
  endtask
  task automatic t_single;
    int n;
    wr(4'h0, 8'h82);
    pulse(24'h2);
    for (n = 0; n < 40 && irq_req !== 1'h1; n++) @(posedge clk_sys) #1;
    chk("latency in range", 16'h1, {15'h0, n >= 6 && n <= 18});
    chk("line pending", 16'h1, {15'h0, irq_line});
    take(16'h000b);
    rd(4'h0);
    chk("global cleared", 16'h02, {8'h0, rd_val});
    rd(4'h8);
    chk("flag cleared", 16'h0, {8'h0, rd_val});
    chk("line cleared", 16'h0, {15'h0, irq_line});
    repeat (12) @(posedge clk_sys);
    rd(4'h0);
    chk("global restored", 16'h82, {8'h0, rd_val});
  endtask
  // Back-to-back power register writes hold off acceptance
  task automatic t_stall;
    logic [3:0] c0;
    wr(4'h0, 8'h82);
    pulse(24'h2);
    c0 = taken_cnt;
    @(posedge clk_sys);
    reg_addr  <= 4'h6;
    reg_wdata <= 8'h00;
    reg_wr    <= 1'h1;
    repeat (20) @(posedge clk_sys);
    reg_wr <= 1'h0;
    #1 chk("stalled", {12'h0, c0}, {12'h0, taken_cnt});
    take(16'h000b);
  endtask
  task automatic t_mask;
    wr(4'h0, 8'h00);
    pulse(24'h20);
    rd(4'h8);
    chk("flag held", 16'h20, {8'h0, rd_val});
    chk("line masked", 16'h0, {15'h0, irq_line});
    wr(4'h0, 8'h20);
    repeat (20) @(posedge clk_sys);
    #1 chk("no take", 16'h0, {15'h0, irq_req});
    wr(4'h0, 8'ha0);
    take(16'h002b);
  endtask
  // Group 0 at level two beats group 2 at level one
  task automatic t_prio;
    slow <= 1'h1;
    wr(4'h4, 8'h04);
    wr(4'h5, 8'h01);
    wr(4'h0, 8'h85);
    pulse(24'h5);
    take(16'h0003);
    take(16'h0013);
    slow <= 1'h0;
  endtask
  task automatic t_group;
    wr(4'h4, 8'h00);
    wr(4'h5, 8'h00);
    wr(4'h1, 8'h02);
    wr(4'h0, 8'h82);
    pulse(24'h82);
    take(16'h000b);
    take(16'h003b);
  endtask
  task automatic t_nmi;
    wr(4'h0, 8'h00);
    nmi_pin <= 1'h1;
    repeat (4) @(posedge clk_sys);
    nmi_pin <= 1'h0;
    take(16'h0000);
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    resetn <= 1'h1;
    t_reset;
    t_single;
    t_stall;
    t_mask;
    t_prio;
    t_group;
    t_nmi;
    report_and_stop;
  end
  // Whole run is a few hundred cycles
  initial begin
    #100us;
    mismatches++;
    report_and_stop;
  end
endmodule // gpic_ctrl_tb
